// [logic/card_window_defs.vh]
`ifndef CARD_WINDOW_DEFS_VH
`define CARD_WINDOW_DEFS_VH

// ----------------------------------------
// Window counts and address layout
// ----------------------------------------
`define MEM_WIN_COUNT 5
`define IO_WIN_COUNT 2
`define MEM_PAGE_LSB 12
`define MEM_PAGE_W 12
`define MEM_PAGE_MIN 12'h001
`define IO_ADDR_W 16
`define ISA_ADDR_W 24
`define CARD_ADDR_W 26

// ----------------------------------------
// Interrupt pins
// ----------------------------------------
`define IRQ_PIN_COUNT 10
`define IRQ_SEL_W 4
`define IRQ_SEL_NONE 4'h0
`define IRQ_LAMP_IDX 4'h7
`define IRQ_RING_IDX 4'h9

// ----------------------------------------
// Extension control register (index 03h)
// ----------------------------------------
`define EXT_CTRL_INDEX 8'h03
`define EXT_CTRL_RESET 8'h00
`define EXT_LAMP_ON_ACCESS_BIT 2

// ----------------------------------------
// Shared interrupt pulse length
// ----------------------------------------
`define SHARED_PULSE_NS 100
`define CLK_PERIOD_NS 10
`define SHARED_PULSE_CYC 8'h0A

`endif

// [logic/window_match.v]
`timescale 1ns/1ps
`include "card_window_defs.vh"

// Single address window: range compare and offset addition
module window_match #(
    parameter AW = 16,
    parameter OW = 16
)(
    input wire en,
    input wire [AW-1:0] addr,
    input wire [AW-1:0] start_addr,
    input wire [AW-1:0] end_addr,
    input wire [OW-1:0] offset,
    output wire hit,
    output wire [OW-1:0] card_addr
);
    // Claim only enabled windows covering the address
    assign hit = en && (addr >= start_addr) && (addr <= end_addr);

    // Card-side address is host address plus window offset
    assign card_addr = addr + offset;
endmodule // window_match

// [logic/card_window_irq_steering.v]
`timescale 1ns/1ps
`include "card_window_defs.vh"
module card_window_irq_steering #(
    parameter NM = `MEM_WIN_COUNT,
    parameter NI = `IO_WIN_COUNT,
    parameter NIRQ = `IRQ_PIN_COUNT
)(
    input wire clk,
    input wire rst,
    input wire [`ISA_ADDR_W-1:0] host_addr,
    input wire host_mem_rd,
    input wire host_mem_wr,
    input wire host_io_rd,
    input wire host_io_wr,
    input wire reg_wr,
    input wire [7:0] reg_index,
    input wire [7:0] reg_wdata,
    output wire [7:0] socket_extension_control,
    input wire [NM-1:0] mem_en,
    input wire [NM*`MEM_PAGE_W-1:0] mem_start,
    input wire [NM*`MEM_PAGE_W-1:0] mem_end,
    input wire [NM*`MEM_PAGE_W-1:0] mem_offset,
    input wire [NM-1:0] mem_wide,
    input wire [NM-1:0] mem_timing_sel,
    input wire [NM-1:0] mem_attr_sel,
    input wire [NM-1:0] mem_wr_protect,
    input wire [NI-1:0] io_en,
    input wire [NI*`IO_ADDR_W-1:0] io_start,
    input wire [NI*`IO_ADDR_W-1:0] io_end,
    input wire [NI*`IO_ADDR_W-1:0] io_offset,
    input wire [NI-1:0] io_auto_size,
    input wire [NI-1:0] io_wide,
    input wire [NI-1:0] io_timing_sel,
    input wire [`IRQ_SEL_W-1:0] card_irq_sel,
    input wire [`IRQ_SEL_W-1:0] mgmt_irq_sel,
    input wire shared_irq_mode,
    input wire card_is_io,
    input wire card_lamp_pass_en,
    input wire ring_out_sel,
    input wire ring_en,
    input wire [4:0] mgmt_event_en,
    input wire mgmt_ack,
    input wire card_present,
    input wire card_active,
    input wire card_io_wide_flag_n,
    input wire card_ready_irq,
    input wire battery_warn_line,
    input wire battery_dead_line,
    input wire card_lamp_input_n,
    input wire card_ring_n,
    output reg card_claim,
    output reg [`CARD_ADDR_W-1:0] card_addr,
    output reg card_wide,
    output reg card_timing_sel,
    output reg card_attr_sel,
    output reg card_write,
    output reg card_read,
    output wire host_data_oe,
    output wire host_cs16_oe,
    output wire host_ready_oe,
    output wire [NIRQ-1:0] irq_out,
    output wire [NIRQ-1:0] irq_oe
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam NS = 8;
    reg [NS-1:0] sync1_q;
    reg [NS-1:0] sync2_q;
    wire [NS-1:0] pins_raw = {card_ring_n, card_lamp_input_n, battery_dead_line, battery_warn_line,
        card_ready_irq, card_io_wide_flag_n, card_active, card_present};
    // Two-stage capture of card pins
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync1_q <= 8'hFF;
            sync2_q <= 8'hFF;
        end
        else
        begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end
    wire present_s = sync2_q[0];
    wire active_s = sync2_q[1];
    wire io16_s = ~sync2_q[2];
    wire ready_s = sync2_q[3];
    wire bwarn_s = sync2_q[4];
    wire bdead_s = sync2_q[5];
    wire lamp_in_low = ~sync2_q[6];
    wire ring_low = ~sync2_q[7];

    // ----------------------------------------
    // Extension control register
    // ----------------------------------------
    reg [7:0] ext_ctrl_q;
    always @(posedge clk)
    begin
        if (rst)
            ext_ctrl_q <= `EXT_CTRL_RESET;
        else if (reg_wr && reg_index == `EXT_CTRL_INDEX)
            ext_ctrl_q <= reg_wdata;
    end
    assign socket_extension_control = ext_ctrl_q;
    wire lamp_on_access_en = ext_ctrl_q[`EXT_LAMP_ON_ACCESS_BIT];

    // ----------------------------------------
    // Window decoders
    // ----------------------------------------
    wire mem_cyc = host_mem_rd | host_mem_wr;
    wire io_cyc = host_io_rd | host_io_wr;
    wire [`MEM_PAGE_W-1:0] host_page = host_addr[`ISA_ADDR_W-1:`MEM_PAGE_LSB];
    wire [NM-1:0] mem_hit;
    wire [NM*`MEM_PAGE_W-1:0] mem_card_page;
    wire [NI-1:0] io_hit;
    wire [NI*`IO_ADDR_W-1:0] io_card_addr;
    genvar g;
    generate
        // One decoder per memory window, page granularity
        for (g = 0; g < NM; g = g + 1)
        begin : g_mem
            wire page_ok = host_page >= `MEM_PAGE_MIN;
            wire raw_hit;
            window_match #(.AW(`MEM_PAGE_W), .OW(`MEM_PAGE_W)) u_mem (
                .en(mem_en[g] & mem_cyc),
                .addr(host_page),
                .start_addr(mem_start[g*`MEM_PAGE_W +: `MEM_PAGE_W]),
                .end_addr(mem_end[g*`MEM_PAGE_W +: `MEM_PAGE_W]),
                .offset(mem_offset[g*`MEM_PAGE_W +: `MEM_PAGE_W]),
                .hit(raw_hit),
                .card_addr(mem_card_page[g*`MEM_PAGE_W +: `MEM_PAGE_W])
            );
            assign mem_hit[g] = raw_hit & page_ok;
        end
        // One decoder per I/O window, byte granularity
        for (g = 0; g < NI; g = g + 1)
        begin : g_io
            window_match #(.AW(`IO_ADDR_W), .OW(`IO_ADDR_W)) u_io (
                .en(io_en[g] & io_cyc),
                .addr(host_addr[`IO_ADDR_W-1:0]),
                .start_addr(io_start[g*`IO_ADDR_W +: `IO_ADDR_W]),
                .end_addr(io_end[g*`IO_ADDR_W +: `IO_ADDR_W]),
                .offset(io_offset[g*`IO_ADDR_W +: `IO_ADDR_W]),
                .hit(io_hit[g]),
                .card_addr(io_card_addr[g*`IO_ADDR_W +: `IO_ADDR_W])
            );
        end
    endgenerate
    // Select the lowest hit window, any memory hit over any I/O hit; overlap is software's problem
    reg claim_d;
    reg [`CARD_ADDR_W-1:0] addr_d;
    reg wide_d;
    reg tsel_d;
    reg attr_d;
    reg wr_d;
    reg rd_d;
    integer i;
    always @*
    begin
        claim_d = 1'b0;
        addr_d = {`CARD_ADDR_W{1'b0}};
        wide_d = 1'b0;
        tsel_d = 1'b0;
        attr_d = 1'b0;
        wr_d = 1'b0;
        rd_d = 1'b0;
        for (i = NI - 1; i >= 0; i = i - 1)
        begin
            if (io_hit[i])
            begin
                claim_d = 1'b1;
                addr_d = {10'h000, io_card_addr[i*`IO_ADDR_W +: `IO_ADDR_W]};
                wide_d = io_auto_size[i] ? io16_s : io_wide[i];
                tsel_d = io_timing_sel[i];
                attr_d = 1'b0;
                wr_d = host_io_wr;
                rd_d = host_io_rd;
            end
        end
        for (i = NM - 1; i >= 0; i = i - 1)
        begin
            if (mem_hit[i])
            begin
                claim_d = 1'b1;
                addr_d = {2'b00, mem_card_page[i*`MEM_PAGE_W +: `MEM_PAGE_W],
                    host_addr[`MEM_PAGE_LSB-1:0]};
                wide_d = mem_wide[i];
                tsel_d = mem_timing_sel[i];
                attr_d = mem_attr_sel[i];
                wr_d = host_mem_wr & ~mem_wr_protect[i];
                rd_d = host_mem_rd;
            end
        end
    end
    // Register card-side cycle outputs
    always @(posedge clk)
    begin
        if (rst)
        begin
            card_claim <= 1'b0;
            card_addr <= {`CARD_ADDR_W{1'b0}};
            card_wide <= 1'b0;
            card_timing_sel <= 1'b0;
            card_attr_sel <= 1'b0;
            card_write <= 1'b0;
            card_read <= 1'b0;
        end
        else
        begin
            card_claim <= claim_d;
            card_addr <= addr_d;
            card_wide <= wide_d;
            card_timing_sel <= tsel_d;
            card_attr_sel <= attr_d;
            card_write <= wr_d;
            card_read <= rd_d;
        end
    end
    // Host bus drivers only while claimed
    assign host_data_oe = card_claim & card_read;
    assign host_cs16_oe = card_claim & card_wide;
    assign host_ready_oe = card_claim;

    // ----------------------------------------
    // Management events and card interrupt
    // ----------------------------------------
    reg [4:0] stat_prev_q;
    reg mgmt_pend_q;
    wire [4:0] stat_now = {ready_s & ~card_is_io, bdead_s, bwarn_s & ~card_is_io, present_s, 1'b0};
    wire [4:0] stat_chg = (stat_now ^ stat_prev_q) & mgmt_event_en;
    wire mgmt_event = |stat_chg[4:1];
    // Sticky management pending; a new event beats the acknowledge
    always @(posedge clk)
    begin
        if (rst)
        begin
            stat_prev_q <= 5'h00;
            mgmt_pend_q <= 1'b0;
        end
        else
        begin
            stat_prev_q <= stat_now;
            mgmt_pend_q <= mgmt_event | (mgmt_pend_q & ~mgmt_ack);
        end
    end
    wire card_irq = card_is_io & present_s & ~ready_s;

    // ----------------------------------------
    // Shared interrupt pulser
    // ----------------------------------------
    reg card_irq_prev_q;
    reg [7:0] pulse_cnt_q;
    always @(posedge clk)
    begin
        if (rst)
        begin
            card_irq_prev_q <= 1'b0;
            pulse_cnt_q <= 8'h00;
        end
        else
        begin
            card_irq_prev_q <= card_irq;
            if (card_irq & ~card_irq_prev_q)
                pulse_cnt_q <= `SHARED_PULSE_CYC;
            else if (pulse_cnt_q != 8'h00)
                pulse_cnt_q <= pulse_cnt_q - 8'h01;
        end
    end
    wire card_drive = shared_irq_mode ? (pulse_cnt_q != 8'h00) : (card_irq_sel != `IRQ_SEL_NONE);
    wire card_level = shared_irq_mode ? 1'b1 : card_irq;
    // ----------------------------------------
    // Lamp and ring logic
    // ----------------------------------------
    wire lamp_mode = lamp_on_access_en | card_lamp_pass_en;
    wire lamp_req = present_s & active_s &
        ((lamp_on_access_en & (card_read | card_write)) |
         (card_lamp_pass_en & card_is_io & lamp_in_low));
    reg ring_hold_q;
    always @(posedge clk)
    begin
        if (rst)
            ring_hold_q <= 1'b0;
        else if (ring_out_sel & ring_en & card_is_io & ring_low)
            ring_hold_q <= 1'b1;
        else if (mem_cyc | io_cyc)
            ring_hold_q <= 1'b0;
    end

    // ----------------------------------------
    // Interrupt pin steering
    // ----------------------------------------
    generate
        for (g = 0; g < NIRQ; g = g + 1)
        begin : g_irq
            wire card_here = (card_irq_sel == g + 1) & card_drive;
            wire mgmt_here = mgmt_irq_sel == g + 1;
            if (g == `IRQ_LAMP_IDX)
            begin : g_lamp
                assign irq_out[g] = lamp_mode ? 1'b0 : (card_here ? card_level : mgmt_pend_q);
                assign irq_oe[g] = lamp_mode ? lamp_req : (card_here | mgmt_here);
            end
            else if (g == `IRQ_RING_IDX)
            begin : g_ring
                assign irq_out[g] = ring_out_sel ? 1'b0 : (card_here ? card_level : mgmt_pend_q);
                assign irq_oe[g] = ring_out_sel ? ring_hold_q : (card_here | mgmt_here);
            end
            else
            begin : g_plain
                assign irq_out[g] = card_here ? card_level : mgmt_pend_q;
                assign irq_oe[g] = card_here | mgmt_here;
            end
        end
    endgenerate
endmodule // card_window_irq_steering

// [verif/card_window_checker_properties.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checks for the window decoder and interrupt steering
// ----------------------------------------
module card_window_checker (
    input wire clk,
    input wire rst,
    input wire host_mem_rd,
    input wire host_mem_wr,
    input wire host_io_rd,
    input wire host_io_wr,
    input wire [7:0] socket_extension_control,
    input wire [3:0] card_irq_sel,
    input wire [3:0] mgmt_irq_sel,
    input wire shared_irq_mode,
    input wire ring_out_sel,
    input wire card_lamp_pass_en,
    input wire card_active,
    input wire card_claim,
    input wire card_write,
    input wire card_read,
    input wire host_data_oe,
    input wire host_cs16_oe,
    input wire host_ready_oe,
    input wire [9:0] irq_out,
    input wire [9:0] irq_oe
);
    // Any host strobe, lamp mode and an interrupt-free setup
    wire strobe = host_mem_rd | host_mem_wr | host_io_rd | host_io_wr;
    wire lamp_mode = socket_extension_control[2] | card_lamp_pass_en;
    wire quiet = card_irq_sel == 4'h0 && mgmt_irq_sel == 4'h0 && !ring_out_sel && !lamp_mode;
    // One clock, one reset for every check
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_idle_no_claim: assert property (!strobe |=> !card_claim)
        else $error("claim without host strobe");
    a_unclaimed_quiet: assert property (!card_claim |-> !(host_data_oe | host_cs16_oe | host_ready_oe))
        else $error("host lines driven while unclaimed");
    a_write_has_cause: assert property (card_write |-> $past(host_mem_wr) || $past(host_io_wr))
        else $error("card write without host write");
    a_claim_has_cycle: assert property (card_claim |-> card_read || card_write || $past(host_mem_wr))
        else $error("claim without card cycle");
    a_lamp_low_only: assert property (lamp_mode && irq_oe[7] |-> !irq_out[7])
        else $error("lamp pin driven high");
    a_lamp_on_access: assert property (socket_extension_control[2] && card_active && $past(card_active, 4)
        && $rose(card_claim) |-> ##[0:2] (irq_oe[7] && !irq_out[7])) else $error("lamp not lit on access");
    a_ring_hold: assert property (ring_out_sel && irq_oe[9] && !irq_out[9] && !strobe && !$past(strobe)
        && !$past(strobe, 2) |=> strobe || (irq_oe[9] && !irq_out[9])) else $error("ring released early");
    a_unrouted_idle: assert property (quiet && $past(quiet) && $past(quiet, 2) |-> irq_oe == 10'h000)
        else $error("unrouted irq pin driven");
    a_shared_pulse: assert property (shared_irq_mode && card_irq_sel == 4'h3 && mgmt_irq_sel != 4'h3
        && $rose(irq_oe[2]) |-> (irq_oe[2] && irq_out[2]) [*8] ##3 !irq_oe[2]) else $error("bad shared pulse");
endmodule // card_window_checker

bind card_window_irq_steering card_window_checker chk_i (.*);

// [verif/card_socket_model.sv]
`timescale 1ns/1ps
// Card socket: pins follow bench requests; with no card, present and active low, other pins high
module card_socket_model (
    input wire inserted,
    input wire powered,
    input wire irq_req,
    input wire ring_req,
    input wire lamp_req,
    input wire wide_io,
    output wire card_present,
    output wire card_active,
    output wire card_io_wide_flag_n,
    output wire card_ready_irq,
    output wire battery_warn_line,
    output wire battery_dead_line,
    output wire card_lamp_input_n,
    output wire card_ring_n
);
    // Pin levels of an inserted I/O card
    assign card_present = inserted;
    assign card_active = inserted & powered;
    assign card_io_wide_flag_n = ~(inserted & wide_io);
    assign card_ready_irq = ~(inserted & irq_req);
    assign battery_warn_line = 1'b1;
    assign battery_dead_line = 1'b1;
    assign card_lamp_input_n = ~(inserted & lamp_req);
    assign card_ring_n = ~(inserted & ring_req);
endmodule // card_socket_model

// [verif/card_window_irq_steering_bench.sv]
`timescale 1ns/1ps
`include "card_window_defs.vh"
module card_window_irq_steering_bench;
    reg clk, rst, host_mem_rd, host_mem_wr, host_io_rd, host_io_wr, reg_wr, mgmt_ack, wide_io;
    reg shared_irq_mode, card_is_io, card_lamp_pass_en, ring_out_sel, ring_en;
    reg inserted, powered, irq_req, ring_req, lamp_req;
    reg [23:0] host_addr;
    reg [7:0] reg_index, reg_wdata;
    reg [4:0] mem_en, mem_wide, mem_timing_sel, mem_attr_sel, mem_wr_protect, mgmt_event_en;
    reg [59:0] mem_start, mem_end, mem_offset;
    reg [1:0] io_en, io_auto_size, io_wide, io_timing_sel;
    reg [31:0] io_start, io_end, io_offset;
    reg [3:0] card_irq_sel, mgmt_irq_sel;
    reg [11:0] pg;
    wire card_present, card_active, card_io_wide_flag_n, card_ready_irq, battery_warn_line;
    wire battery_dead_line, card_lamp_input_n, card_ring_n, card_claim, card_wide, card_timing_sel;
    wire card_attr_sel, card_write, card_read, host_data_oe, host_cs16_oe, host_ready_oe;
    wire [7:0] socket_extension_control;
    wire [25:0] card_addr;
    wire [9:0] irq_out, irq_oe;
    integer num_errors = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    integer i, n;

    card_window_irq_steering uut (.*);
    card_socket_model socket (.*);

    // 100 MHz clock
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    // Cut a hung run short
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            num_errors = num_errors + 1;
            close_out;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Drop host strobes, then let k cycles pass
    task idle(input integer k);
        {host_mem_rd, host_mem_wr, host_io_rd, host_io_wr} = 4'h0;
        repeat (k) @(negedge clk);
    endtask

    // One host cycle; strobe stays up until the next call or idle
    task acc(input [3:0] kind, input [23:0] a);
        host_addr = a;
        {host_mem_rd, host_mem_wr, host_io_rd, host_io_wr} = kind;
        @(posedge clk);
        @(negedge clk);
    endtask

    task wr_ext(input [7:0] idx, input [7:0] d);
        reg_index = idx;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
        @(negedge clk);
    endtask

    task close_out;
        $display("compares %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        {host_mem_rd, host_mem_wr, host_io_rd, host_io_wr, reg_wr, mgmt_ack, shared_irq_mode} = 0;
        {card_lamp_pass_en, ring_out_sel, ring_en, irq_req, ring_req, lamp_req, host_addr, reg_index} = 0;
        {reg_wdata, mem_en, mgmt_event_en, card_irq_sel, mgmt_irq_sel} = 0;
        {rst, inserted, powered, wide_io, card_is_io} = 5'b11111;
        // Disjoint windows so no two claim one address
        for (i = 0; i < 5; i = i + 1)
        begin
            mem_start[12*i +: 12] = 12'h010 * (i + 1);
            mem_end[12*i +: 12] = 12'h010 * (i + 1) + 12'h003;
            mem_offset[12*i +: 12] = 12'h100 * (i + 1);
        end
        {mem_wide, mem_timing_sel, mem_attr_sel, mem_wr_protect} = 20'h5_A904;
        {io_start, io_end, io_offset} = {32'h0300_03F8, 32'h0307_03FF, 32'h1000_0008};
        {io_en, io_auto_size, io_wide, io_timing_sel} = 8'hDA;
        repeat (4) @(negedge clk);
        rst = 0;
        idle(2);
        chk("ext reset", `EXT_CTRL_RESET, socket_extension_control);
        // Memory windows: end boundary, one page past it, disabled
        mem_en = 5'h1F;
        for (i = 0; i < 5; i = i + 1)
        begin
            pg = 12'h010 * (i + 1) + 12'h003;
            acc(4'h8, {pg, 12'hFFF});
            chk("mem claim", 3'b111, {card_claim, host_data_oe, host_ready_oe});
            chk("mem addr", {2'b00, pg + 12'h100 * (i + 1), 12'hFFF}, card_addr);
            chk("mem mode", {mem_wide[i], mem_wide[i], mem_timing_sel[i], mem_attr_sel[i], 1'b1},
                {card_wide, host_cs16_oe, card_timing_sel, card_attr_sel, card_read});
            acc(4'h8, {pg + 12'h001, 12'h000});
            chk("mem past end", 4'h0, {card_claim, host_data_oe, host_cs16_oe, host_ready_oe});
        end
        mem_en = 5'h1E;
        acc(4'h8, 24'h010_000);
        chk("mem off", 0, card_claim);
        acc(4'h4, 24'h031_010);
        chk("wp write", 2'b10, {card_claim, card_write});
        acc(4'h8, 24'h031_010);
        chk("wp read", 2'b11, {card_claim, card_read});
        acc(4'h4, 24'h040_010);
        chk("mem write", 2'b11, {card_claim, card_write});
        $display("test memory done");
        // I/O windows: auto size both ways, manual width, end+1, disabled
        acc(4'h2, 24'h0003FF);
        chk("io auto", {32'h0000_0407, 3'b110}, {card_addr, card_claim, card_wide, card_timing_sel});
        acc(4'h1, 24'h000400);
        chk("io past end", 0, card_claim);
        wide_io = 0;
        idle(4);
        acc(4'h2, 24'h0003F8);
        chk("io narrow", 2'b10, {card_claim, card_wide});
        acc(4'h1, 24'h000300);
        chk("io manual", {32'h0000_1300, 4'hF}, {card_addr, card_claim, card_write, card_wide, card_timing_sel});
        io_en = 2'b01;
        acc(4'h2, 24'h000300);
        chk("io off", 0, card_claim);
        $display("test io done");
        // Card interrupt to every pin in turn
        for (n = 1; n <= 10; n = n + 1)
        begin
            card_irq_sel = n;
            irq_req = 1;
            idle(5);
            chk("irq pin", {10'h1 << (n - 1), 10'h1 << (n - 1)}, {irq_oe, irq_out & irq_oe});
            irq_req = 0;
            idle(5);
        end
        card_irq_sel = 0;
        // Management interrupt on removal, then ack
        mgmt_irq_sel = 5;
        mgmt_event_en = 5'h02;
        inserted = 0;
        idle(6);
        chk("mgmt set", 2'b11, {irq_oe[4], irq_out[4]});
        mgmt_ack = 1;
        idle(1);
        mgmt_ack = 0;
        idle(2);
        chk("mgmt ack", 0, irq_out[4] & irq_oe[4]);
        {mgmt_irq_sel, mgmt_event_en, inserted} = 10'h001;
        // Shared mode pulse length
        idle(6);
        shared_irq_mode = 1;
        card_irq_sel = 3;
        irq_req = 1;
        n = 0;
        repeat (20)
        begin
            @(negedge clk);
            n = n + irq_oe[2];
        end
        chk("pulse len", {`SHARED_PULSE_CYC, 1'b0}, {n[7:0], irq_oe[2]});
        {irq_req, shared_irq_mode, card_irq_sel} = 0;
        $display("test irq done");
        // Register and lamp
        wr_ext(8'h05, 8'hFF);
        chk("ext other", 8'h00, socket_extension_control);
        wr_ext(`EXT_CTRL_INDEX, 8'h04);
        chk("ext write", 8'h04, socket_extension_control);
        acc(4'h8, 24'h040_000);
        chk("lamp access", 2'b10, {irq_oe[7], irq_out[7]});
        powered = 0;
        idle(4);
        acc(4'h8, 24'h040_000);
        chk("lamp masked", 0, irq_oe[7]);
        wr_ext(`EXT_CTRL_INDEX, 8'h00);
        {powered, card_lamp_pass_en, lamp_req} = 3'b111;
        idle(4);
        chk("lamp pass", 2'b10, {irq_oe[7], irq_out[7]});
        {card_lamp_pass_en, lamp_req} = 0;
        $display("test lamp done");
        // Ring holds IRQ15 low until host activity
        {ring_out_sel, ring_en, ring_req} = 3'b111;
        idle(4);
        ring_req = 0;
        idle(4);
        chk("ring held", 2'b10, {irq_oe[9], irq_out[9]});
        acc(4'h2, 24'h000FFF);
        idle(2);
        chk("ring off", 0, irq_oe[9]);
        ring_out_sel = 0;
        idle(3);
        $display("test ring done");
        close_out;
    end
endmodule // card_window_irq_steering_bench
